// ---- rtl/bri_read_if.sv ----
// bus read interface: single and quad reads on a multiplexed bus
//
// Summary of operation
// R1: permit memory drive only after releasing bus
// R2: hold address past latch strobe, drivers off first
// R3: turnaround order: strobe low, tri-state, permit
// R4: quad select low for quad, high single
// R5: word index 00 for quad, else address
// R6: capture strobe samples bus into buffer
// R7: transfer accept releases core early
// R8: memory times early accept to feed core
// R9: accept may coincide with first capture strobe
// R10: implicit end after one or four captures
// R11: bus fault ends read, raises exception
// R12: debug one: miss type, then address bit 3
// R13: debug two: reference kind, then bit 2
// R14: miss enters stall, raises fetch request
// R15: start on reference rising edge when free
// R16: start: read strobe, address, latch strobe
// R17: permit stays off during address phase
// R18: turnaround done within first clock's second half
// R19: first strobe sample at second clock start
// R20: latch data on following falling edge
// R21: only capture strobe causes sampling
// R22: all timing refers to reference clock
// R23: address 31:4 high, byte lanes low
// R24: quad word index counts up from zero
// R25: index steps per capture, quad select stable
//
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "bri_defs.svh"

module bri_read_if
  import bri_pkg::*;
#(
  parameter int unsigned REF_HALF = `BRI_REF_HALF
) (
  // clock, reset, clock enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // execution core side
  input wire logic core_miss,
  input wire logic [31:0] core_addr,
  input wire logic core_quad,
  input wire logic [3:0] core_lanes,
  input wire logic core_instr,
  input wire logic core_uncached,
  input wire logic higher_prio_pending,
  output logic internal_fetch_request,
  output logic core_release,
  output logic read_done,
  output logic fault_exception,
  // memory bus pins
  output logic bus_reference_clock,
  output logic read_strobe,
  output logic addr_latch_strobe,
  output logic [31:0] ad_out,
  output logic ad_oe,
  input wire logic [31:0] ad_in,
  output logic quad_select_n,
  output logic [1:0] word_index,
  output logic memory_drive_permit_n,
  input wire logic read_capture_strobe,
  input wire logic transfer_accept,
  input wire logic bus_fault_in,
  output logic debug_miss,
  output logic debug_ref,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================================
  // reference clock phase
  localparam logic [3:0] PH_LAST = 4'(2 * REF_HALF - 1);
  localparam logic [3:0] PH_FALL = 4'(REF_HALF);

  logic [3:0] ph; // position inside one reference period
  logic [3:0] next_ph; // phase one clock later
  wire at_rise = (ph == PH_LAST); // next edge raises the reference
  wire at_fall = (ph == PH_FALL - 4'h1); // next edge lowers it
  assign next_ph = at_rise ? 4'h0 : ph + 4'h1;

  // the reference clock is a divided copy of clk, so every bus event
  // lands on a known clk edge and no second domain exists
  always_ff @(posedge clk) begin
    if (reset) begin
      ph <= 4'h0;
      bus_reference_clock <= 1'b1;
    end else if (ce) begin
      ph <= next_ph;
      bus_reference_clock <= (next_ph < PH_FALL); // see R22
    end
  end

  // ==========================================================
  // pin synchronisers: two flops before any logic looks
  logic [34:0] sync_a; // first stage, read only by the second
  logic [34:0] sync_b; // second stage, safe to use
  wire [31:0] ad_s = sync_b[31:0];
  wire strobe_s = sync_b[32];
  wire accept_s = sync_b[33];
  wire fault_s = sync_b[34];

  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= '0;
      sync_b <= '0;
    end else if (ce) begin
      sync_a <= {bus_fault_in, transfer_accept, read_capture_strobe, ad_in};
      sync_b <= sync_a;
    end
  end

  // ==========================================================
  // control and status registers
  logic [1:0] ctrl; // enable and force-single bits
  logic fault_seen; // sticky fault flag
  bri_state_e state; // sequencer state
  logic req_quad; // latched read kind
  logic [31:0] req_addr; // latched target address
  logic [2:0] word_cnt; // captures seen in this read
  logic cap_pend; // strobe seen, capture at falling edge
  logic accepted; // core already released
  logic core_uncached_q; // reference was uncacheable
  logic instr_q; // reference was an instruction fetch
  logic [31:0] miss_addr; // address that missed

  // quad only for cacheable misses; data refills may be forced single
  wire want_quad = core_quad & ~core_uncached &
                   (core_instr | ~ctrl[`BRI_CTRL_SINGLE]);
  wire [2:0] last_cnt = req_quad ? `BRI_QUAD_LAST : `BRI_SINGLE_LAST;

  // ==========================================================
  // sequencer decode
  wire start_ok = (state == ST_STALL) && at_rise &&
                  !higher_prio_pending; // see R15
  wire sample = (state == ST_DATA) && (ph == 4'h0); // see R19
  wire fault_end = sample && fault_s; // see R11
  wire accept_end = sample && accept_s && !req_quad && !strobe_s;
  wire buf_wr = (state == ST_DATA) && at_fall && cap_pend; // see R20
  wire cnt_end = buf_wr && (word_cnt == last_cnt); // see R10
  wire read_end = fault_end || accept_end || cnt_end;

  // ==========================================================
  // read buffer
  logic [31:0] buf_rdata; // word selected for apb
  bri_read_buffer #(
    .WIDTH(32),
    .DEPTH(4)
  ) u_buf (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .wr_en(buf_wr), // see R6
    .wr_idx(word_cnt[1:0]),
    .wr_data(ad_s),
    .rd_idx(paddr[3:2]),
    .rd_data(buf_rdata)
  );

  // ==========================================================
  // sequencer state
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          // miss in run cycle: next cycle is a stall
          if (core_miss && ctrl[`BRI_CTRL_EN]) begin
            state <= ST_STALL; // see R14
          end
        end
        ST_STALL: begin
          // further stall cycles while something outranks us
          if (start_ok) begin
            state <= ST_ADDR;
          end
        end
        ST_ADDR: begin
          // turnaround finishes one clk before the next rising edge
          if (ph == PH_LAST - 4'h1) begin
            state <= ST_DATA; // see R18
          end
        end
        ST_DATA: begin
          if (read_end) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // request latch and internal fetch request
  always_ff @(posedge clk) begin
    if (reset) begin
      req_quad <= 1'b0;
      req_addr <= 32'h0000_0000;
      internal_fetch_request <= 1'b0;
    end else if (ce) begin
      if (state == ST_IDLE && core_miss && ctrl[`BRI_CTRL_EN]) begin
        req_quad <= want_quad;
        req_addr <= {core_addr[31:4], core_lanes};
        internal_fetch_request <= 1'b1; // see R14
      end else if (start_ok) begin
        internal_fetch_request <= 1'b0;
      end
    end
  end

  // ==========================================================
  // address phase and bus turnaround
  // each step is one clk apart so latch strobe, driver release and
  // permit can never overlap, at the cost of a longer reference period
  always_ff @(posedge clk) begin
    if (reset) begin
      read_strobe <= 1'b0;
      addr_latch_strobe <= 1'b0;
      ad_out <= 32'h0000_0000;
      ad_oe <= 1'b0;
      memory_drive_permit_n <= 1'b1;
      quad_select_n <= 1'b1;
    end else if (ce) begin
      if (start_ok) begin
        read_strobe <= 1'b1; // see R16
        addr_latch_strobe <= 1'b1; // see R16
        ad_out <= req_addr; // see R23
        ad_oe <= 1'b1;
        memory_drive_permit_n <= 1'b1; // see R17
        quad_select_n <= ~req_quad; // see R4 R25
      end else if (state == ST_ADDR && at_fall) begin
        addr_latch_strobe <= 1'b0; // address still held, see R2 R3
      end else if (state == ST_ADDR && ph == PH_FALL) begin
        ad_oe <= 1'b0; // see R3
      end else if (state == ST_ADDR && ph == PH_LAST - 4'h1) begin
        memory_drive_permit_n <= ad_oe; // only once released, see R1
      end else if (state == ST_DATA && read_end) begin
        read_strobe <= 1'b0;
        memory_drive_permit_n <= 1'b1;
        quad_select_n <= 1'b1;
      end
    end
  end

  // ==========================================================
  // word index, debug pins and capture counting
  always_ff @(posedge clk) begin
    if (reset) begin
      word_index <= 2'h0;
      debug_miss <= 1'b0;
      debug_ref <= 1'b0;
      word_cnt <= 3'h0;
      cap_pend <= 1'b0;
    end else if (ce) begin
      if (start_ok) begin
        // quad starts at the block base, single shows its word
        word_index <= req_quad ? 2'h0 : miss_addr[3:2]; // see R5 R24
        debug_miss <= ~core_uncached_q; // see R12
        debug_ref <= instr_q; // see R13
        word_cnt <= 3'h0;
        cap_pend <= 1'b0;
      end else if (state == ST_ADDR && ph == PH_LAST - 4'h1) begin
        debug_miss <= miss_addr[3]; // see R12
        debug_ref <= miss_addr[2]; // see R13
      end else if (sample) begin
        // transfer accept never arms a capture
        cap_pend <= strobe_s && !fault_s; // see R21
      end else if (buf_wr) begin
        cap_pend <= 1'b0;
        word_cnt <= word_cnt + 3'h1;
        if (req_quad) begin
          word_index <= word_index + 2'h1; // see R24 R25
        end
      end
    end
  end

  // ==========================================================
  // kind of miss, kept for the debug pins
  always_ff @(posedge clk) begin
    if (reset) begin
      core_uncached_q <= 1'b0;
      instr_q <= 1'b0;
      miss_addr <= 32'h0000_0000;
    end else if (ce && state == ST_IDLE && core_miss) begin
      core_uncached_q <= core_uncached;
      instr_q <= core_instr;
      miss_addr <= core_addr;
    end
  end

  // ==========================================================
  // core handshakes: release, completion, exception
  always_ff @(posedge clk) begin
    if (reset) begin
      accepted <= 1'b0;
      core_release <= 1'b0;
      read_done <= 1'b0;
      fault_exception <= 1'b0;
    end else if (ce) begin
      core_release <= 1'b0;
      read_done <= read_end;
      fault_exception <= fault_end; // see R11
      if (start_ok) begin
        accepted <= 1'b0;
      end else if (sample && accept_s && !accepted && !fault_s) begin
        // early accept lets the core run while words still arrive
        accepted <= 1'b1; // see R7
        core_release <= 1'b1;
      end else if (cnt_end && !accepted) begin
        core_release <= 1'b1; // implicit accept, see R10
      end
    end
  end

  // ==========================================================
  // apb slave: one wait state, then a single ready pulse
  wire apb_acc = psel && penable && !pready;
  wire apb_fire = psel && penable && pready;
  wire hit_ctrl = (paddr == `BRI_OFF_CTRL);
  wire hit_stat = (paddr == `BRI_OFF_STATUS);
  wire hit_buf = (paddr >= `BRI_OFF_BUF0) && (paddr <= `BRI_OFF_BUF3) &&
                 (paddr[1:0] == 2'h0);
  wire hit_any = hit_ctrl || hit_stat || hit_buf;
  wire [31:0] stat_word = {25'h0, word_cnt, 1'b0, req_quad,
                           fault_seen, (state != ST_IDLE)};
  wire [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl} :
                       hit_stat ? stat_word :
                       hit_buf ? buf_rdata : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      pready <= apb_acc;
      pslverr <= apb_acc && !hit_any;
      if (apb_acc) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // register writes land on the edge that samples pready
  // a fault in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl <= `BRI_CTRL_RESET;
      fault_seen <= 1'b0;
    end else if (ce) begin
      if (apb_fire && pwrite && hit_ctrl) begin
        ctrl <= pwdata[1:0];
      end
      if (fault_end) begin
        fault_seen <= 1'b1;
      end else if (apb_fire && pwrite && hit_stat &&
                   pwdata[`BRI_ST_FAULT]) begin
        fault_seen <= 1'b0;
      end
    end
  end

  // ==========================================================
  // checks
  chk_permit_addr: assert property (@(posedge clk) disable iff (reset) // see R17
    addr_latch_strobe |-> memory_drive_permit_n)
    else $error("permit in address phase");

  chk_oe_permit: assert property (@(posedge clk) disable iff (reset) // see R1
    !memory_drive_permit_n |-> !ad_oe)
    else $error("permit while driving");

  chk_turn_order: assert property (@(posedge clk) disable iff (reset) // see R3
    $fell(ad_oe) |-> !addr_latch_strobe && !$past(addr_latch_strobe)
                     && memory_drive_permit_n)
    else $error("turnaround order");

  chk_quad_sel: assert property (@(posedge clk) disable iff (reset) // see R4
    $rose(addr_latch_strobe) |-> (quad_select_n == !req_quad)
                                 && (ad_out[31:4] == req_addr[31:4]))
    else $error("bad start pins");

  chk_word_base: assert property (@(posedge clk) disable iff (reset) // see R5
    $rose(addr_latch_strobe) && req_quad |-> word_index == 2'h0)
    else $error("quad not at word 0");

  chk_start_edge: assert property (@(posedge clk) disable iff (reset) // see R15
    $rose(read_strobe) |-> bus_reference_clock && ph == 4'h0
                           && addr_latch_strobe)
    else $error("start off rising edge");

  chk_cap_fall: assert property (@(posedge clk) disable iff (reset) // see R20
    ce && sample && strobe_s && !fault_s |-> ##2 buf_wr)
    else $error("capture edge");

  chk_only_strobe: assert property (@(posedge clk) disable iff (reset) // see R21
    buf_wr |-> cap_pend)
    else $error("write without strobe");

  chk_fault_end: assert property (@(posedge clk) disable iff (reset) // see R11
    ce && fault_end |=> !read_strobe && fault_exception && state == ST_IDLE)
    else $error("fault did not end");

  chk_quad_end: assert property (@(posedge clk) disable iff (reset) // see R10
    ce && buf_wr && req_quad && word_cnt == 3'h3 |=> !read_strobe
                                                    && word_index == 2'h0)
    else $error("quad not ended");

endmodule : bri_read_if

`default_nettype wire

// ---- rtl/bri_defs.svh ----
// bus read interface constants
`ifndef BRI_DEFS_SVH
`define BRI_DEFS_SVH

// ==========================================================
// register offsets (byte addresses)
`define BRI_OFF_CTRL 8'h00
`define BRI_OFF_STATUS 8'h04
`define BRI_OFF_BUF0 8'h10
`define BRI_OFF_BUF3 8'h1C

// ==========================================================
// control register fields and reset value
`define BRI_CTRL_EN 0
`define BRI_CTRL_SINGLE 1
`define BRI_CTRL_RESET 2'h1

// ==========================================================
// status register fields
`define BRI_ST_BUSY 0
`define BRI_ST_FAULT 1
`define BRI_ST_QUAD 2
`define BRI_ST_CNT_LO 4

// ==========================================================
// timing and counts
`define BRI_REF_HALF 3
`define BRI_QUAD_LAST 3'h3
`define BRI_SINGLE_LAST 3'h0

`endif

// ---- rtl/bri_pkg.sv ----
// bus read interface types
package bri_pkg;

  // ==========================================================
  // read sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_STALL,
    ST_ADDR,
    ST_DATA
  } bri_state_e;

  // one bus word
  typedef logic [31:0] bri_word_t;

endpackage : bri_pkg

// ---- rtl/bri_read_buffer.sv ----
// on-chip read buffer: flip-flop words written by index
`timescale 1ns/1ps
`default_nettype none

module bri_read_buffer #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  // read side
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);

  // ==========================================================
  // storage
  logic [WIDTH-1:0] mem [DEPTH]; // buffered words

  // one register per entry, written only when its index matches
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk) begin
        if (reset) begin
          mem[gi] <= '0;
        end else if (ce && wr_en && (wr_idx == gi)) begin
          mem[gi] <= wr_data;
        end
      end
    end
  endgenerate

  // read port is a plain mux of the flops
  assign rd_data = mem[rd_idx];

endmodule : bri_read_buffer

`default_nettype wire

// ---- dv/bri_mem_model.sv ----
// memory-side partner model for the bus read interface
`timescale 1ns/1ps
`default_nettype none

module bri_mem_model #(
  parameter int REF_HALF = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // bus pins from the device
  input wire logic bus_reference_clock,
  input wire logic read_strobe,
  input wire logic quad_select_n,
  input wire logic memory_drive_permit_n,
  // bus pins to the device
  output logic [31:0] ad_in,
  output logic read_capture_strobe,
  output logic transfer_accept,
  output logic bus_fault_in,
  // mode 0 plain, 1 early accept, 2 bare accept, 3 fault; gap; base
  input wire logic [1:0] mode,
  input wire logic [2:0] gap,
  input wire logic [31:0] data_base
);
  // ==========================================================
  // reference clock tracking
  logic ref_q; // last reference level
  logic [3:0] ph; // 1 on the edge after a rise
  logic [2:0] sent; // words offered in this read
  logic [2:0] wait_n; // idle periods still to go
  logic [31:0] word; // word behind the memory drivers
  // act on the falling reference edge
  wire slot = (ph == 4'(REF_HALF - 1));
  wire [2:0] need = quad_select_n ? 3'h1 : 3'h4; // words per read

  // local phase follows the reference clock
  always @(posedge clk) begin
    ref_q <= bus_reference_clock;
    ph <= (bus_reference_clock && !ref_q) ? 4'h1 : ph + 4'h1;
  end

  // ==========================================================
  // one decision per reference period
  always @(posedge clk) begin
    if (reset || !read_strobe) begin
      sent <= 3'h0;
      wait_n <= gap;
      read_capture_strobe <= 1'b0;
      transfer_accept <= 1'b0;
      bus_fault_in <= 1'b0;
    end else if (slot) begin
      read_capture_strobe <= 1'b0;
      transfer_accept <= 1'b0;
      if (wait_n != 3'h0) begin
        // let a period pass
        wait_n <= wait_n - 3'h1;
      end else if (mode == 2'h3) begin
        bus_fault_in <= 1'b1;
      end else if (mode == 2'h2 && sent == 3'h0) begin
        // accept with no word offered
        transfer_accept <= 1'b1;
        sent <= need;
      end else if (sent < need) begin
        read_capture_strobe <= 1'b1;
        // in mode 1, accept with the first word, whatever the gap
        transfer_accept <= (mode == 2'h1) && (sent == 3'h0);
        word <= data_base + 32'(sent);
        sent <= sent + 3'h1;
        wait_n <= gap;
      end
    end
  end

  // drive only while permitted, else a changing pattern
  always @(posedge clk) begin
    if (reset) begin
      ad_in <= 32'h0;
    end else if (!memory_drive_permit_n) begin
      ad_in <= word;
    end else begin
      ad_in <= ~ad_in;
    end
  end
endmodule : bri_mem_model

`default_nettype wire

// ---- dv/bri_read_if_tb_top.sv ----
// bench for the bus read interface
`timescale 1ns/1ps
`default_nettype none
`include "bri_defs.svh"

module bri_read_if_tb_top;
  // ==========================================================
  // design pins
  logic clk, reset, core_miss, core_quad, core_instr, core_uncached;
  logic [31:0] core_addr, ad_out, ad_in, pwdata, prdata;
  logic [3:0] core_lanes;
  logic higher_prio_pending, internal_fetch_request, core_release;
  logic read_done, fault_exception, bus_reference_clock, read_strobe;
  logic addr_latch_strobe, ad_oe, quad_select_n, memory_drive_permit_n;
  logic [1:0] word_index, mem_mode;
  logic read_capture_strobe, transfer_accept, bus_fault_in;
  logic debug_miss, debug_ref, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [2:0] mem_gap; // idle periods the memory inserts
  logic [31:0] mem_base; // first word the memory returns
  logic fs; // force-single bit as last written
  logic [31:0] rdv;
  logic rde;
  int err_total = 0, samples_checked = 0;

  bri_read_if #(.REF_HALF(`BRI_REF_HALF)) uut (
    .clk(clk), .reset(reset), .ce(1'b1), .core_miss(core_miss),
    .core_addr(core_addr), .core_quad(core_quad), .core_lanes(core_lanes),
    .core_instr(core_instr), .core_uncached(core_uncached),
    .higher_prio_pending(higher_prio_pending),
    .internal_fetch_request(internal_fetch_request),
    .core_release(core_release), .read_done(read_done),
    .fault_exception(fault_exception),
    .bus_reference_clock(bus_reference_clock), .read_strobe(read_strobe),
    .addr_latch_strobe(addr_latch_strobe), .ad_out(ad_out), .ad_oe(ad_oe),
    .ad_in(ad_in), .quad_select_n(quad_select_n), .word_index(word_index),
    .memory_drive_permit_n(memory_drive_permit_n),
    .read_capture_strobe(read_capture_strobe),
    .transfer_accept(transfer_accept), .bus_fault_in(bus_fault_in),
    .debug_miss(debug_miss), .debug_ref(debug_ref), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  bri_mem_model #(.REF_HALF(`BRI_REF_HALF)) mem (
    .clk(clk), .reset(reset), .bus_reference_clock(bus_reference_clock),
    .read_strobe(read_strobe), .quad_select_n(quad_select_n),
    .memory_drive_permit_n(memory_drive_permit_n), .ad_in(ad_in),
    .read_capture_strobe(read_capture_strobe),
    .transfer_accept(transfer_accept), .bus_fault_in(bus_fault_in),
    .mode(mem_mode), .gap(mem_gap), .data_base(mem_base));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // apb: setup, then access held until pready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk(32'(pready), 32'h1, "pready");
    rdv = prdata;
    rde = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp,
                        input logic xerr);
    apb(1'b0, a, 32'h0);
    chk(rdv, exp, "read data");
    chk(32'(rde), 32'(xerr), "slave error");
  endtask : reg_rd

  // one read, miss to end; hold delays start
  task automatic do_read(input logic [31:0] a, input logic qd,
      input logic ins, input logic unc, input logic [1:0] md, input int hold);
    logic q;
    int n, rel_at, done_at, flt;
    q = qd & !unc & (ins | !fs);
    mem_mode <= md;
    higher_prio_pending <= (hold > 0);
    core_miss <= 1'b1;
    core_addr <= a;
    core_quad <= qd;
    core_instr <= ins;
    core_uncached <= unc;
    core_lanes <= a[7:4];
    @(posedge clk);
    core_miss <= 1'b0;
    @(posedge clk);
    chk(32'(internal_fetch_request), 32'h1, "fetch request");
    repeat (hold) begin
      @(posedge clk);
      chk(32'(read_strobe), 32'h0, "start held back");
    end
    higher_prio_pending <= 1'b0;
    n = 0;
    while (read_strobe !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(32'(bus_reference_clock), 32'h1, "start edge");
    chk(32'({read_strobe, addr_latch_strobe, ad_oe, memory_drive_permit_n}),
        32'hF, "start pins");
    chk(ad_out, {a[31:4], a[7:4]}, "address");
    chk(32'({quad_select_n, word_index}), 32'({!q, q ? 2'b00 : a[3:2]}),
        "size");
    chk(32'({debug_miss, debug_ref}), 32'({!unc, ins}), "debug");
    repeat (2) @(posedge clk);
    chk(32'({addr_latch_strobe, ad_oe}), 32'h3, "latch held");
    @(posedge clk);
    chk(32'({addr_latch_strobe, ad_oe, memory_drive_permit_n}), 32'h3,
        "latch first");
    @(posedge clk);
    chk(32'({ad_oe, memory_drive_permit_n}), 32'h1, "release");
    @(posedge clk);
    chk(32'({memory_drive_permit_n, debug_miss, debug_ref}),
        32'({1'b0, a[3], a[2]}), "turned");
    rel_at = -1;
    done_at = -1;
    flt = 0;
    n = 0;
    while (done_at < 0 && n < 400) begin
      @(posedge clk);
      n++;
      if (read_strobe === 1'b1)
        chk(32'({quad_select_n, memory_drive_permit_n}), 32'({!q, 1'b0}),
            "held");
      if (core_release === 1'b1 && rel_at < 0) rel_at = n;
      if (fault_exception === 1'b1) flt = 1;
      if (read_done === 1'b1) done_at = n;
    end
    chk(32'(done_at > 0), 32'h1, "ended");
    chk(32'(flt), 32'(md == 2'h3), "fault");
    if (md == 2'h1) chk(32'(rel_at > 0 && rel_at < done_at), 32'h1, "early");
    if (md == 2'h0) chk(32'(rel_at), 32'(done_at), "implicit");
    if (md < 2'h2) begin
      for (int i = 0; i < (q ? 4 : 1); i++) begin
        reg_rd(8'h10 + 8'(4 * i), mem_base + 32'(i), 1'b0);
      end
    end
  endtask : do_read

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  // ==========================================================
  // test sequence
  initial begin
    {core_miss, core_quad, core_instr, core_uncached, fs} = '0;
    {higher_prio_pending, psel, penable, pwrite} = '0;
    {core_addr, core_lanes, paddr, pwdata} = '0;
    {mem_mode, mem_gap, mem_base} = '0;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    reg_rd(`BRI_OFF_CTRL, 32'(`BRI_CTRL_RESET), 1'b0);
    reg_rd(8'h40, 32'h0, 1'b1);
    $display("test registers done");
    mem_base <= 32'hA000_0000;
    do_read(32'h1234_567C, 1'b1, 1'b1, 1'b0, 2'h0, 0);
    apb(1'b0, `BRI_OFF_STATUS, 32'h0);
    chk(32'(rdv[6:4]), 32'h4, "words counted");
    $display("test quad implicit done");
    mem_base <= 32'hB000_0000;
    do_read(32'h0F0F_0F94, 1'b1, 1'b0, 1'b0, 2'h1, 0);
    $display("test quad early accept done");
    mem_gap <= 3'h2;
    mem_base <= 32'hC000_0000;
    do_read(32'h8765_4328, 1'b1, 1'b0, 1'b1, 2'h0, 0);
    $display("test single slow done");
    mem_base <= 32'hD000_0000;
    do_read(32'h4444_4444, 1'b0, 1'b0, 1'b1, 2'h2, 0);
    reg_rd(`BRI_OFF_BUF0, 32'hC000_0000, 1'b0);
    $display("test bare accept done");
    mem_gap <= 3'h0;
    do_read(32'h2000_0010, 1'b1, 1'b1, 1'b0, 2'h3, 8);
    apb(1'b0, `BRI_OFF_STATUS, 32'h0);
    chk(32'(rdv[`BRI_ST_FAULT]), 32'h1, "fault sticky");
    apb(1'b1, `BRI_OFF_STATUS, 32'h1 << `BRI_ST_FAULT);
    apb(1'b0, `BRI_OFF_STATUS, 32'h0);
    chk(32'(rdv[`BRI_ST_FAULT]), 32'h0, "fault cleared");
    $display("test fault done");
    fs = 1'b1;
    apb(1'b1, `BRI_OFF_CTRL, 32'h3);
    mem_base <= 32'hE000_0000;
    do_read(32'h3000_0008, 1'b1, 1'b0, 1'b0, 2'h0, 0);
    apb(1'b1, `BRI_OFF_CTRL, 32'h0);
    core_miss <= 1'b1;
    @(posedge clk);
    core_miss <= 1'b0;
    repeat (20) @(posedge clk);
    chk(32'({internal_fetch_request, read_strobe}), 32'h0, "disabled");
    $display("test force single and disable done");
    tally_and_finish();
  end
endmodule : bri_read_if_tb_top

`default_nettype wire
